//--- inc/tpc_defs.svh
// Constants for the shared timer prescaler, clock select and timer0 flag block.
`ifndef TPC_DEFS_SVH
`define TPC_DEFS_SVH
`define TPC_ADDR_MASK 2'h0
`define TPC_ADDR_FLAGS 2'h1
`define TPC_ADDR_PSCTL 2'h2
`define TPC_ADDR_T1FLAGS 2'h3
`define TPC_BIT_CMP_A 0
`define TPC_BIT_OVF 1
`define TPC_BIT_CMP_B 2
`define TPC_MASK_USED 8'h07
`define TPC_PSCTL_USED 8'h01
`define TPC_T1_USED 8'h03
`define TPC_RESET_VALUE 8'h00
`define TPC_DIV_WIDTH 10
`define TPC_MAX_FF 8'hFF
`define TPC_BOTTOM 8'h00
`endif

//--- inc/tpc_pkg.sv
// Types for the shared timer prescaler and timer0 flag block.
package tpc_pkg;
   typedef enum logic [2:0] {
      TPC_CS_STOP = 3'h0,
      TPC_CS_DIV1 = 3'h1,
      TPC_CS_DIV8 = 3'h2,
      TPC_CS_DIV64 = 3'h3,
      TPC_CS_DIV256 = 3'h4,
      TPC_CS_DIV1024 = 3'h5,
      TPC_CS_EXT_FALL = 3'h6,
      TPC_CS_EXT_RISE = 3'h7
   } tpc_clock_select_type;
   typedef struct packed {
      logic cmp_b;
      logic overflow;
      logic cmp_a;
   } tpc_t0_events_type;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } tpc_bus_req_type;
endpackage

//--- rtl/tpc_timer_prescaler.sv
// Shared prescaler, clock-select tick generation and timer0 interrupt flags.
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "tpc_defs.svh"
module tpc_timer_prescaler
   import tpc_pkg::*;
#(
   parameter int DIV_WIDTH = `TPC_DIV_WIDTH
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire tpc_bus_req_type bus_req,
   output logic [7:0] bus_rdata,
   input wire logic [2:0] t0_clock_select,
   input wire logic [2:0] t1_clock_select,
   input wire logic t0_ext_count_pin,
   input wire logic t1_ext_count_pin,
   input wire logic [7:0] t0_count,
   input wire logic t0_count_advance,
   input wire logic [2:0] t0_waveform_mode,
   input wire logic [7:0] t0_compare_a_value,
   input wire logic [7:0] t0_compare_b_value,
   input wire logic t1_cmp_a_match,
   input wire logic t1_cmp_b_match,
   input wire logic global_irq_en,
   input wire tpc_t0_events_type t0_vector_ack,
   input wire logic [1:0] t1_vector_ack,
   output logic t0_count_tick,
   output logic t1_count_tick,
   output tpc_t0_events_type t0_irq_req,
   output logic [1:0] t1_irq_req
);

   // Reset release: asserted at once, removed through two flops.
   logic rst_meta_ff;
   logic rst_sync_ff;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end
   wire logic srst_n = rst_sync_ff;

   // Tap select shared by both timers; external selects never see the divider.
   function automatic logic pick_tick(input logic [2:0] sel,
                                      input logic [DIV_WIDTH-1:0] div,
                                      input logic rise,
                                      input logic fall);
      logic t;
      t = 1'b0;
      unique case (tpc_clock_select_type'(sel))
         TPC_CS_STOP: t = 1'b0;
         TPC_CS_DIV1: t = 1'b1;
         TPC_CS_DIV8: t = (div[2:0] == 3'h7);
         TPC_CS_DIV64: t = (div[5:0] == 6'h3F);
         TPC_CS_DIV256: t = (div[7:0] == 8'hFF);
         TPC_CS_DIV1024: t = (div == {DIV_WIDTH{1'b1}});
         TPC_CS_EXT_FALL: t = fall;
         TPC_CS_EXT_RISE: t = rise;
      endcase
      return t;
   endfunction

   // Register decode.
   logic wr_mask;
   logic wr_flags;
   logic wr_psctl;
   logic wr_t1flags;
   always_comb begin
      wr_mask = bus_req.wr && (bus_req.addr == {6'h00, `TPC_ADDR_MASK});
      wr_flags = bus_req.wr && (bus_req.addr == {6'h00, `TPC_ADDR_FLAGS});
      wr_psctl = bus_req.wr && (bus_req.addr == {6'h00, `TPC_ADDR_PSCTL});
      wr_t1flags = bus_req.wr && (bus_req.addr == {6'h00, `TPC_ADDR_T1FLAGS});
   end

   // Free-running divider; it ignores both clock selects entirely.
   logic [DIV_WIDTH-1:0] div_ff;
   logic [DIV_WIDTH-1:0] nxt_div;
   always_comb begin
      if (wr_psctl && bus_req.wdata[0]) begin
         nxt_div = '0;
      end else begin
         nxt_div = div_ff + 1'b1;
      end
   end

   // Pin synchronisers: three flops per pin, edges taken where two and three differ.
   // The first flop only feeds the second, so metastability cannot reach the detector.
   logic [2:0] t0_pin_ff;
   logic [2:0] t1_pin_ff;
   logic [2:0] nxt_t0_pin;
   logic [2:0] nxt_t1_pin;
   always_comb begin
      nxt_t0_pin = {t0_pin_ff[1:0], t0_ext_count_pin};
      nxt_t1_pin = {t1_pin_ff[1:0], t1_ext_count_pin};
   end
   logic t0_rise;
   logic t0_fall;
   logic t1_rise;
   logic t1_fall;
   always_comb begin
      t0_rise = t0_pin_ff[1] & ~t0_pin_ff[2];
      t0_fall = ~t0_pin_ff[1] & t0_pin_ff[2];
      t1_rise = t1_pin_ff[1] & ~t1_pin_ff[2];
      t1_fall = ~t1_pin_ff[1] & t1_pin_ff[2];
   end

   // Registered ticks; one pulse per selected event, about three cycles after a pin edge.
   logic t0_tick_ff;
   logic t1_tick_ff;
   logic nxt_t0_tick;
   logic nxt_t1_tick;
   always_comb begin
      nxt_t0_tick = pick_tick(t0_clock_select, div_ff, t0_rise, t0_fall);
      nxt_t1_tick = pick_tick(t1_clock_select, div_ff, t1_rise, t1_fall);
   end
   assign t0_count_tick = t0_tick_ff & clk_en;
   assign t1_count_tick = t1_tick_ff & clk_en;

   // Timer0 event detection; match and overflow are judged when the count advances.
   logic ovf_event;
   logic cmp_a_event;
   logic cmp_b_event;
   always_comb begin
      cmp_a_event = t0_count_advance && (t0_count == t0_compare_a_value);
      cmp_b_event = t0_count_advance && (t0_count == t0_compare_b_value);
      unique case (t0_waveform_mode)
         3'h1, 3'h5: ovf_event = t0_count_advance && (t0_count == `TPC_BOTTOM);
         3'h7: ovf_event = t0_count_advance && (t0_count == t0_compare_a_value);
         default: ovf_event = t0_count_advance && (t0_count == `TPC_MAX_FF);
      endcase
   end

   // Flags: set wins over a same-cycle clear by write-one or vector entry.
   logic [7:0] mask_ff;
   logic [7:0] nxt_mask;
   tpc_t0_events_type flags_ff;
   tpc_t0_events_type nxt_flags;
   logic [1:0] t1_flags_ff;
   logic [1:0] nxt_t1_flags;
   tpc_t0_events_type clr;
   tpc_t0_events_type setv;
   always_comb begin
      nxt_mask = wr_mask ? (bus_req.wdata & `TPC_MASK_USED) : mask_ff;
      setv = '{cmp_b: cmp_b_event, overflow: ovf_event, cmp_a: cmp_a_event};
      clr = t0_vector_ack;
      if (wr_flags) begin
         clr = clr | bus_req.wdata[2:0];
      end
      nxt_flags = (flags_ff & ~clr) | setv;
      nxt_t1_flags = t1_flags_ff & ~t1_vector_ack;
      if (wr_t1flags) begin
         nxt_t1_flags = nxt_t1_flags & ~bus_req.wdata[1:0];
      end
      nxt_t1_flags = nxt_t1_flags | {t1_cmp_b_match, t1_cmp_a_match};
   end

   // Timer0 requests need the mask bit, the flag and the global enable together; timer1 requests need only the flag and the global enable.
   always_comb begin
      t0_irq_req.cmp_b = global_irq_en & mask_ff[`TPC_BIT_CMP_B] & flags_ff.cmp_b;
      t0_irq_req.overflow = global_irq_en & mask_ff[`TPC_BIT_OVF] & flags_ff.overflow;
      t0_irq_req.cmp_a = global_irq_en & mask_ff[`TPC_BIT_CMP_A] & flags_ff.cmp_a;
      t1_irq_req = {2{global_irq_en}} & t1_flags_ff;
   end

   // Read data, one cycle after the strobe; unmapped reads return zero.
   logic [7:0] rdata_ff;
   logic [7:0] nxt_rdata;
   always_comb begin
      nxt_rdata = 8'h00;
      if (bus_req.rd) begin
         unique case (bus_req.addr)
            {6'h00, `TPC_ADDR_MASK}: nxt_rdata = mask_ff;
            {6'h00, `TPC_ADDR_FLAGS}: nxt_rdata = {5'h00, flags_ff};
            {6'h00, `TPC_ADDR_PSCTL}: nxt_rdata = 8'h00; // self-clearing bit 0
            {6'h00, `TPC_ADDR_T1FLAGS}: nxt_rdata = {6'h00, t1_flags_ff};
            default: nxt_rdata = 8'h00;
         endcase
      end
   end
   assign bus_rdata = rdata_ff;

   // All state registers except the reset synchroniser; the clock enable freezes all of these.
   always_ff @(posedge mclk or negedge srst_n) begin
      if (!srst_n) begin
         div_ff <= '0;
         t0_pin_ff <= 3'h0;
         t1_pin_ff <= 3'h0;
         t0_tick_ff <= 1'b0;
         t1_tick_ff <= 1'b0;
         mask_ff <= `TPC_RESET_VALUE;
         flags_ff <= '0;
         t1_flags_ff <= 2'h0;
         rdata_ff <= 8'h00;
      end else if (clk_en) begin
         div_ff <= nxt_div;
         t0_pin_ff <= nxt_t0_pin;
         t1_pin_ff <= nxt_t1_pin;
         t0_tick_ff <= nxt_t0_tick;
         t1_tick_ff <= nxt_t1_tick;
         mask_ff <= nxt_mask;
         flags_ff <= nxt_flags;
         t1_flags_ff <= nxt_t1_flags;
         rdata_ff <= nxt_rdata;
      end
   end

endmodule
`default_nettype wire

//--- dv/tpc_props.sv
// Port checks for the shared prescaler and timer0 flag block.
`timescale 1ns/1ps
`default_nettype none
module tpc_props
   import tpc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire tpc_bus_req_type bus_req,
   input wire logic [7:0] bus_rdata,
   input wire logic [2:0] t0_clock_select,
   input wire logic global_irq_en,
   input wire logic t0_count_tick,
   input wire logic t0_ext_count_pin,
   input wire tpc_t0_events_type t0_irq_req
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // Reads of the mask and flags, and of the prescaler control register.
   sequence rd_low;
      bus_req.rd && clk_en && bus_req.addr < 8'h02;
   endsequence
   sequence rd_ctl;
      bus_req.rd && clk_en && bus_req.addr == 8'h02;
   endsequence
   // Requests must never show while the global enable is off.
   chk_gate_b: assert property (t0_irq_req.cmp_b |-> global_irq_en)
      else $error("compare B request without global enable");
   chk_gate_ovf: assert property (t0_irq_req.overflow |-> global_irq_en)
      else $error("overflow request without global enable");
   chk_gate_a: assert property (t0_irq_req.cmp_a |-> global_irq_en)
      else $error("compare A request without global enable");
   chk_low_resv: assert property (rd_low |=> bus_rdata[7:3] == 5'h00)
      else $error("reserved mask or flag bits read set");
   chk_ctl_zero: assert property (rd_ctl |=> bus_rdata == 8'h00)
      else $error("prescaler control read not zero");
   // Tick shape per clock source; three cycles let a stale tick drain.
   chk_stop_quiet: assert property (t0_clock_select == 3'h0 [*3] |-> !t0_count_tick)
      else $error("tick with no clock source");
   chk_div1_tick: assert property ((t0_clock_select == 3'h1 && clk_en) [*5] |-> t0_count_tick)
      else $error("undivided source missed a cycle");
   chk_tick_single: assert property (t0_clock_select > 3'h1 ##1
      t0_count_tick && t0_clock_select > 3'h1 ##1 t0_clock_select > 3'h1 |-> !t0_count_tick)
      else $error("divided tick longer than one cycle");
   // A pin rise shows as a tick three edges later, or two when the pin moved on an edge.
   chk_pin_delay: assert property ((t0_clock_select == 3'h7 && clk_en) [*3] ##0
      $rose(t0_ext_count_pin) |-> ##[2:3] t0_count_tick)
      else $error("pin rise gave no tick in time");
endmodule
bind tpc_timer_prescaler tpc_props tpc_props_inst (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en),
   .bus_req(bus_req), .bus_rdata(bus_rdata), .t0_clock_select(t0_clock_select),
   .global_irq_en(global_irq_en), .t0_count_tick(t0_count_tick),
   .t0_ext_count_pin(t0_ext_count_pin), .t0_irq_req(t0_irq_req));
`default_nettype wire

//--- dv/tpc_pin_model.sv
// Far-side source of the external count clock.
`timescale 1ns/1ps
`default_nettype none
module tpc_pin_model (
   input wire logic run,
   output logic pin
);
   // Toggles every 103 ns while run is high and stands still otherwise.
   initial begin
      pin = 1'b0;
      forever #103 if (run) pin = ~pin;
   end
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// Self-checking bench for the shared prescaler and timer0 flag block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import tpc_pkg::*;
   logic mclk = 0, rst_n = 0, adv = 0, a1 = 0, run = 0, clk_en = 1, gie = 0, tk0, tk1, pin;
   logic [7:0] rdat, cnt = 0;
   logic [1:0] t1q;
   logic [2:0] wm = 0;
   logic [2:0] s0 = 0;
   tpc_bus_req_type bq = '0;
   tpc_t0_events_type ack = '0, irq;
   int bad_count = 0, check_count = 0, ticks = 0, rises = 0, falls = 0, n;
   tpc_timer_prescaler tpc_timer_prescaler_inst (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en),
      .bus_req(bq), .bus_rdata(rdat), .t0_clock_select(s0), .t1_clock_select(s0),
      .t0_ext_count_pin(pin), .t1_ext_count_pin(pin), .t0_count(cnt), .t0_count_advance(adv),
      .t0_waveform_mode(wm), .t0_compare_a_value(8'h10), .t0_compare_b_value(8'h20),
      .t1_cmp_a_match(a1), .t1_cmp_b_match(a1), .global_irq_en(gie), .t0_vector_ack(ack),
      .t1_vector_ack(2'h0), .t0_count_tick(tk0), .t1_count_tick(tk1), .t0_irq_req(irq),
      .t1_irq_req(t1q));
   tpc_pin_model tpc_pin_model_inst (.run(run), .pin(pin));
   // System clock, and tallies of settled ticks and pin edges.
   initial begin
      forever #20 mclk = ~mclk;
   end
   always @(posedge mclk) #1 ticks += 32'(tk0 === 1'b1);
   always @(posedge pin) rises++;
   always @(negedge pin) falls++;
   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   // Task-driven inputs move 1 ns after an edge, so they cannot race the sampling.
   task automatic step(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      bq <= '{a, d, w, !w};
      step(1);
      bq <= '0;
      if (!w) chk(32'(rdat), 32'(d));
      step(1);
   endtask
   task automatic ev(input logic [7:0] c);
      cnt <= c;
      adv <= 1'b1;
      step(1);
      adv <= 1'b0;
      step(1);
   endtask
   // Bounded wait for the next timer0 tick; n ends one above the cycles spent.
   task automatic await_tick;
      for (n = 1; tk0 !== 1'b1; n++) begin
         if (n > 1100) begin
            bad_count++;
            $display("wrong value at %0t: no timer tick before the limit", $time);
            close_out();
         end
         step(1);
      end
   endtask
   task automatic t_flags;
      bus(0, 8'h01, 8'h00);
      bus(1, 8'h00, 8'hFF);
      bus(0, 8'h00, 8'h07);
      bus(0, 8'h50, 8'h00);
      ev(8'h10);
      ev(8'h20);
      ev(8'hFF);
      bus(0, 8'h01, 8'h07);
      chk(32'(irq), 32'h0);
      gie <= 1'b1;
      step(1);
      chk(32'(irq), 32'h7);
      bus(1, 8'h01, 8'h02);
      bus(0, 8'h01, 8'h05);
      ack <= 3'h1;
      step(1);
      ack <= 3'h0;
      bus(0, 8'h01, 8'h04);
      bus(1, 8'h00, 8'h03);
      chk(32'(irq), 32'h0);
      a1 <= 1'b1;
      step(1);
      a1 <= 1'b0;
      bus(0, 8'h03, 8'h03);
      chk(32'(t1q), 32'h3);
      bus(1, 8'h03, 8'h01);
      bus(0, 8'h03, 8'h02);
      // Overflow point moves with the waveform mode: bottom in mode 1, compare A in mode 7.
      bus(1, 8'h01, 8'h07);
      wm <= 3'h1;
      ev(8'hFF);
      ev(8'h00);
      bus(0, 8'h01, 8'h02);
      bus(1, 8'h01, 8'h07);
      wm <= 3'h7;
      ev(8'h10);
      bus(0, 8'h01, 8'h03);
      // A compare-B match in the same cycle as its write-one clear must leave the flag set.
      cnt <= 8'h20;
      adv <= 1'b1;
      bq <= '{8'h01, 8'h04, 1'b1, 1'b0};
      step(1);
      adv <= 1'b0;
      bq <= '0;
      step(1);
      bus(0, 8'h01, 8'h07);
      $display("flag test done");
   endtask
   task automatic t_div;
      int dv[4] = '{8, 64, 256, 1024};
      s0 <= 3'h1;
      step(6);
      chk(32'(tk0), 32'h1);
      clk_en <= 1'b0;
      step(3);
      chk(32'(tk0), 32'h0);
      clk_en <= 1'b1;
      step(1);
      chk(32'(tk0), 32'h1);
      for (int i = 0; i < 4; i++) begin
         s0 <= 3'h0;
         step(2);
         s0 <= 3'(i + 2);
         await_tick;
         chk(32'(n <= dv[i] + 2), 32'h1);
         step(1);
         await_tick;
         chk(32'(n), 32'(dv[i]));
         chk(32'(tk1), 32'h1);
      end
      step(500);
      bus(0, 8'h02, 8'h00);
      bus(1, 8'h02, 8'h01);
      await_tick;
      chk(32'(n), 32'(dv[3]));
      $display("divider test done");
   endtask
   task automatic t_ext;
      int r, f, t, e;
      for (int m = 6; m < 9; m++) begin
         s0 <= (m == 8) ? 3'h0 : 3'(m);
         step(2);
         r = rises;
         f = falls;
         t = ticks;
         run <= 1'b1;
         step(60);
         run <= 1'b0;
         step(10);
         e = (m == 6) ? falls - f : (m == 7) ? rises - r : 0;
         chk(32'(ticks - t), 32'(e));
      end
      $display("pin clock test done");
   endtask
   initial begin
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      step(3);
      t_flags;
      t_div;
      t_ext;
      close_out;
   end
endmodule
`default_nettype wire
